// ---- input_capture_consts.svh ----
`ifndef INPUT_CAPTURE_CONSTS_SVH
`define INPUT_CAPTURE_CONSTS_SVH
// ==========================================================
// register byte offsets
`define IC_OFF_CTRL 12'h000
`define IC_OFF_BUF 12'h004
`define IC_OFF_STAT 12'h008
`define IC_OFF_MASK 12'h00c
// ==========================================================
// control register field positions
`define IC_POS_HALT 13
`define IC_POS_TSEL 7
`define IC_POS_ICI 5
`define IC_POS_OVF 4
`define IC_POS_BNE 3
`define IC_POS_MODE 0
// ==========================================================
// capture mode codes
`define IC_MODE_OFF 3'h0
`define IC_MODE_EDGE 3'h1
`define IC_MODE_FALL 3'h2
`define IC_MODE_RISE 3'h3
`define IC_MODE_PRE4 3'h4
`define IC_MODE_PRE16 3'h5
`define IC_MODE_UNUSED 3'h6
`define IC_MODE_WAKE 3'h7
// ==========================================================
// counts and reset values
`define IC_PRE4_LAST 4'h3
`define IC_PRE16_LAST 4'hf
`define IC_FIFO_DEPTH 3'h4
`define IC_CTRL_RST 7'h00
`define IC_IRQ_RST 3'h0
`endif

// ---- input_capture_pkg.sv ----
package input_capture_pkg;
  // writable control fields
  typedef struct packed {
    logic halt;
    logic tsel;
    logic [1:0] ici;
    logic [2:0] mode;
  } ctrl_t;
  // edges seen on the synchronised pin
  typedef struct packed {
    logic rise;
    logic fall;
  } pin_edge_t;
  // interrupt status and mask layout, bit 2 downward
  typedef struct packed {
    logic wake;
    logic ovf;
    logic cap;
  } irq_t;
  typedef enum {IDX_CTRL, IDX_BUF, IDX_STAT, IDX_MASK, IDX_NONE} reg_idx_t;
endpackage

// ---- capture_edge_detect.sv ----
`timescale 1ns/1ps
// ==========================================================
// pin synchroniser and edge detector
module capture_edge_detect (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  input wire logic pin_i,
  output input_capture_pkg::pin_edge_t edge_o
);
  logic sync1_q;
  logic sync2_q;
  logic last_q;

  // two flops against metastability, third for the edge
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      last_q <= 1'b0;
    end else if (en_i) begin
      sync1_q <= pin_i;
      sync2_q <= sync1_q;
      last_q <= sync2_q;
    end
  end

  // one-cycle edge pulses
  assign edge_o.rise = sync2_q & ~last_q;
  assign edge_o.fall = ~sync2_q & last_q;
endmodule

// ---- capture_fifo.sv ----
`timescale 1ns/1ps
`include "input_capture_consts.svh"
// ==========================================================
// four-word capture buffer, oldest first
module capture_fifo (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  input wire logic clear_i,
  input wire logic push_i,
  input wire logic [15:0] data_i,
  input wire logic pop_i,
  output logic [15:0] head_o,
  output logic [2:0] count_o,
  output logic full_o,
  output logic empty_o
);
  logic [15:0] mem_q [0:3];
  logic [1:0] wp_q;
  logic [1:0] rp_q;
  logic [2:0] count_q;
  logic do_push;
  logic do_pop;

  // push into a full buffer is dropped; caller flags it
  assign do_push = push_i & ~full_o & ~clear_i;
  assign do_pop = pop_i & ~empty_o & ~clear_i;

  // storage carries no reset, only the pointers do
  always_ff @(posedge clk_i) begin
    if (en_i && do_push) begin
      mem_q[wp_q] <= data_i;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk_i) begin
    if (!nrst_i || (en_i && clear_i)) begin
      wp_q <= 2'h0;
      rp_q <= 2'h0;
      count_q <= 3'h0;
    end else if (en_i) begin
      if (do_push) begin
        wp_q <= wp_q + 2'h1;
      end
      if (do_pop) begin
        rp_q <= rp_q + 2'h1;
      end
      count_q <= count_q + {2'h0, do_push} - {2'h0, do_pop};
    end
  end

  assign head_o = empty_o ? 16'h0000 : mem_q[rp_q];
  assign count_o = count_q;
  assign full_o = (count_q == `IC_FIFO_DEPTH);
  assign empty_o = (count_q == 3'h0);
endmodule

// ---- input_capture_channel.sv ----
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "input_capture_consts.svh"
// ==========================================================
// input capture channel with apb register access
module input_capture_channel (
  input wire logic CLOCK_I,
  input wire logic NRST_I,
  input wire logic CLK_EN_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic CAPTURE_INPUT_PIN_I,
  input wire logic [15:0] TIMER_A_COUNT_I,
  input wire logic [15:0] TIMER_B_COUNT_I,
  input wire logic CPU_IDLE_I,
  input wire logic CPU_SLEEP_I,
  output logic IRQ_O,
  output logic WAKE_O
);
  // ==========================================================
  // declarations
  input_capture_pkg::ctrl_t ctrl_q;
  input_capture_pkg::irq_t stat_q;
  input_capture_pkg::irq_t stat_d;
  input_capture_pkg::irq_t stat_set;
  input_capture_pkg::irq_t stat_clr;
  input_capture_pkg::irq_t mask_q;
  input_capture_pkg::irq_t mask_d;
  input_capture_pkg::pin_edge_t pin_edge;
  input_capture_pkg::reg_idx_t idx;
  logic ovf_q;
  logic [3:0] pre_q;
  logic [1:0] per_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic irq_q;
  logic wake_q;
  logic access;
  logic rd_latch;
  logic wr_en;
  logic mode_off;
  logic capture_mode;
  logic low_power;
  logic run;
  logic cap_evt;
  logic cap_push;
  logic ovf_evt;
  logic cap_irq_evt;
  logic wake_evt;
  logic pop;
  logic [3:0] pre_last;
  logic [15:0] cap_value;
  logic [15:0] fifo_head;
  logic [2:0] fifo_count;
  logic fifo_full;
  logic fifo_empty;
  logic [31:0] rd_value;

  // shared by the read mux and the write strobes
  function automatic input_capture_pkg::reg_idx_t decode_addr(input logic [11:0] a);
    case (a)
      `IC_OFF_CTRL: decode_addr = input_capture_pkg::IDX_CTRL;
      `IC_OFF_BUF: decode_addr = input_capture_pkg::IDX_BUF;
      `IC_OFF_STAT: decode_addr = input_capture_pkg::IDX_STAT;
      `IC_OFF_MASK: decode_addr = input_capture_pkg::IDX_MASK;
      default: decode_addr = input_capture_pkg::IDX_NONE;
    endcase
  endfunction

  // ==========================================================
  // submodules
  capture_edge_detect u_edge (
    .clk_i(CLOCK_I),
    .nrst_i(NRST_I),
    .en_i(CLK_EN_I),
    .pin_i(CAPTURE_INPUT_PIN_I),
    .edge_o(pin_edge)
  );

  capture_fifo u_fifo (
    .clk_i(CLOCK_I),
    .nrst_i(NRST_I),
    .en_i(CLK_EN_I),
    .clear_i(mode_off),
    .push_i(cap_push),
    .data_i(cap_value),
    .pop_i(pop),
    .head_o(fifo_head),
    .count_o(fifo_count),
    .full_o(fifo_full),
    .empty_o(fifo_empty)
  );

  // ==========================================================
  // bus decode
  // data is latched in the first access cycle, so buffer pops happen there
  assign idx = decode_addr(PADDR_I);
  assign access = PSEL_I & PENABLE_I;
  assign rd_latch = access & ~pready_q & ~PWRITE_I;
  assign wr_en = access & pready_q & PWRITE_I;
  assign pop = rd_latch & (idx == input_capture_pkg::IDX_BUF);

  // ==========================================================
  // capture qualification
  assign mode_off = (ctrl_q.mode == `IC_MODE_OFF) || (ctrl_q.mode == `IC_MODE_UNUSED);
  assign capture_mode = ~mode_off && (ctrl_q.mode != `IC_MODE_WAKE);
  assign low_power = CPU_IDLE_I | CPU_SLEEP_I;
  assign run = capture_mode & ~(CPU_IDLE_I & ctrl_q.halt);
  assign pre_last = (ctrl_q.mode == `IC_MODE_PRE16) ? `IC_PRE16_LAST : `IC_PRE4_LAST;

  // event selection per mode
  always_comb begin
    cap_evt = 1'b0;
    unique case (ctrl_q.mode)
      `IC_MODE_EDGE: cap_evt = pin_edge.rise | pin_edge.fall;
      `IC_MODE_FALL: cap_evt = pin_edge.fall;
      `IC_MODE_RISE: cap_evt = pin_edge.rise;
      `IC_MODE_PRE4,
      `IC_MODE_PRE16: cap_evt = pin_edge.rise & (pre_q == pre_last);
      default: cap_evt = 1'b0;
    endcase
    cap_evt = cap_evt & run;
  end

  assign cap_value = ctrl_q.tsel ? TIMER_A_COUNT_I : TIMER_B_COUNT_I;
  assign cap_push = cap_evt & ~fifo_full;
  assign ovf_evt = cap_evt & fifo_full;
  assign cap_irq_evt = cap_evt & ((ctrl_q.mode == `IC_MODE_EDGE) || (per_q == ctrl_q.ici));
  assign wake_evt = low_power &
                    (((ctrl_q.mode == `IC_MODE_WAKE) & pin_edge.rise) | cap_evt);

  // ==========================================================
  // prescaler for the 4th and 16th rising edge modes
  always_ff @(posedge CLOCK_I) begin
    if (!NRST_I) begin
      pre_q <= 4'h0;
    end else if (CLK_EN_I) begin
      if (ctrl_q.mode != `IC_MODE_PRE4 && ctrl_q.mode != `IC_MODE_PRE16) begin
        pre_q <= 4'h0;
      end else if (run && pin_edge.rise) begin
        pre_q <= (pre_q == pre_last) ? 4'h0 : pre_q + 4'h1;
      end
    end
  end

  // captures-per-interrupt counter, idle in both-edge mode
  always_ff @(posedge CLOCK_I) begin
    if (!NRST_I) begin
      per_q <= 2'h0;
    end else if (CLK_EN_I) begin
      if (mode_off || ctrl_q.mode == `IC_MODE_EDGE) begin
        per_q <= 2'h0;
      end else if (cap_evt) begin
        per_q <= (per_q == ctrl_q.ici) ? 2'h0 : per_q + 2'h1;
      end
    end
  end

  // ==========================================================
  // control and overflow state
  always_ff @(posedge CLOCK_I) begin
    if (!NRST_I) begin
      ctrl_q <= `IC_CTRL_RST;
    end else if (CLK_EN_I && wr_en && idx == input_capture_pkg::IDX_CTRL) begin
      ctrl_q.halt <= PWDATA_I[`IC_POS_HALT];
      ctrl_q.tsel <= PWDATA_I[`IC_POS_TSEL];
      ctrl_q.ici <= PWDATA_I[`IC_POS_ICI +: 2];
      ctrl_q.mode <= PWDATA_I[`IC_POS_MODE +: 3];
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!NRST_I) begin
      ovf_q <= 1'b0;
    end else if (CLK_EN_I) begin
      if (mode_off) begin
        ovf_q <= 1'b0;
      end else if (ovf_evt) begin
        ovf_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // interrupt status, mask and outputs
  // set beats a simultaneous write-one clear
  assign stat_set = '{wake: wake_evt, ovf: ovf_evt, cap: cap_irq_evt};
  assign stat_clr = (wr_en && idx == input_capture_pkg::IDX_STAT) ? PWDATA_I[2:0] : `IC_IRQ_RST;
  assign stat_d = (stat_q & ~stat_clr) | stat_set;
  assign mask_d = (wr_en && idx == input_capture_pkg::IDX_MASK) ? PWDATA_I[2:0] : mask_q;

  always_ff @(posedge CLOCK_I) begin
    if (!NRST_I) begin
      stat_q <= `IC_IRQ_RST;
      mask_q <= `IC_IRQ_RST;
      irq_q <= 1'b0;
      wake_q <= 1'b0;
    end else if (CLK_EN_I) begin
      stat_q <= stat_d;
      mask_q <= mask_d;
      irq_q <= |(stat_d & mask_d);
      wake_q <= wake_evt;
    end
  end

  // ==========================================================
  // apb read data and handshake, one wait state per access
  always_comb begin
    rd_value = 32'h0000_0000;
    unique case (idx)
      input_capture_pkg::IDX_CTRL: begin
        rd_value[`IC_POS_HALT] = ctrl_q.halt;
        rd_value[`IC_POS_TSEL] = ctrl_q.tsel;
        rd_value[`IC_POS_ICI +: 2] = ctrl_q.ici;
        rd_value[`IC_POS_OVF] = ovf_q;
        rd_value[`IC_POS_BNE] = ~fifo_empty;
        rd_value[`IC_POS_MODE +: 3] = ctrl_q.mode;
      end
      input_capture_pkg::IDX_BUF: rd_value[15:0] = fifo_head;
      input_capture_pkg::IDX_STAT: rd_value[2:0] = stat_q;
      input_capture_pkg::IDX_MASK: rd_value[2:0] = mask_q;
      input_capture_pkg::IDX_NONE: rd_value = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLOCK_I) begin
    if (!NRST_I) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (CLK_EN_I) begin
      pready_q <= access & ~pready_q;
      pslverr_q <= access & ~pready_q & (idx == input_capture_pkg::IDX_NONE);
      prdata_q <= rd_latch ? rd_value : 32'h0000_0000;
    end
  end

  assign PRDATA_O = prdata_q;
  assign PREADY_O = pready_q;
  assign PSLVERR_O = pslverr_q;
  assign IRQ_O = irq_q;
  assign WAKE_O = wake_q;

  // ==========================================================
  // assertions
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!NRST_I);

  sequence s_push_alone;
    CLK_EN_I && cap_push && !pop;
  endsequence

  sequence s_first_into_empty;
    s_push_alone ##0 fifo_empty;
  endsequence

  a_capture_stores: assert property (s_push_alone |=> fifo_count == $past(fifo_count) + 3'h1)
    else $error("capture event did not add a buffer entry");
  a_timer_select: assert property (s_first_into_empty |=>
      fifo_head == ($past(ctrl_q.tsel) ? $past(TIMER_A_COUNT_I) : $past(TIMER_B_COUNT_I)))
    else $error("captured value is not the selected timer");
  a_irq_divider: assert property (cap_irq_evt && ctrl_q.mode != `IC_MODE_EDGE |-> per_q == ctrl_q.ici)
    else $error("capture interrupt at wrong capture count");
  a_prescale_hit: assert property (cap_evt && ctrl_q.mode == `IC_MODE_PRE16 |-> pre_q == 4'hf)
    else $error("sixteenth edge prescale fired early");
  a_every_edge: assert property (run && ctrl_q.mode == `IC_MODE_EDGE &&
      (pin_edge.rise || pin_edge.fall) |-> cap_irq_evt)
    else $error("both-edge mode missed an interrupt");
  a_wake_mode: assert property (ctrl_q.mode == `IC_MODE_WAKE |-> !cap_evt)
    else $error("wake-only mode captured a value");
  a_fifo_depth: assert property (fifo_count <= `IC_FIFO_DEPTH)
    else $error("buffer fill level above four");
  a_bne_read: assert property (CLK_EN_I && rd_latch && idx == input_capture_pkg::IDX_CTRL
      |=> PRDATA_O[`IC_POS_BNE] == !$past(fifo_empty))
    else $error("not-empty status disagrees with buffer");
  a_overflow_set: assert property (CLK_EN_I && cap_evt && fifo_full && !pop |=> ovf_q && fifo_full)
    else $error("overflow not flagged on full buffer");
  a_idle_halt: assert property (CPU_IDLE_I && ctrl_q.halt |-> !cap_evt)
    else $error("capture while halted in idle");
  a_wake_pulse: assert property (CLK_EN_I && low_power && cap_evt |=> WAKE_O ##0 stat_q.wake)
    else $error("pin event did not raise wake");
  a_off_flush: assert property (CLK_EN_I && mode_off |=> fifo_empty && !ovf_q)
    else $error("turning off did not flush the buffer");
  a_apb_ready: assert property (CLK_EN_I && access && !pready_q |=> PREADY_O)
    else $error("apb access not answered after one wait state");

  // ==========================================================
  // status, overflow drop and clock-enable freeze
  sequence s_frozen;
    !CLK_EN_I;
  endsequence

  sequence s_full_capture;
    CLK_EN_I && ovf_evt && !pop;
  endsequence

  a_full_drop: assert property (s_full_capture |=> fifo_full && $stable(fifo_head))
    else $error("capture into a full buffer changed the oldest entry");
  a_set_wins: assert property (CLK_EN_I && cap_irq_evt |=> stat_q.cap)
    else $error("capture interrupt status not set");
  a_status_sticky: assert property (CLK_EN_I && stat_q.cap &&
      !(wr_en && idx == input_capture_pkg::IDX_STAT && PWDATA_I[0]) |=> stat_q.cap)
    else $error("capture status cleared without a write of one");
  a_enable_freeze: assert property (s_frozen |=> $stable(ctrl_q) && $stable(stat_q) &&
      $stable(fifo_count) && $stable(ovf_q) && $stable(PREADY_O))
    else $error("state moved while the clock enable was low");
endmodule

// ---- capture_pin_model.sv ----
`timescale 1ns/1ps
// ==========================================================
// external signal source for the capture pin
module capture_pin_model (
  input wire logic clk_i,
  output logic pin_o
);
  initial begin
    pin_o = 1'b0;
  end
  // whole pulses, three cycles per level so every edge is seen apart
  task automatic pulses(input int n);
    for (int i = 0; i < n; i++) begin
      pin_o <= 1'b1;
      repeat (3) @(posedge clk_i);
      pin_o <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
    // let the last edge clear the synchroniser and land
    repeat (6) @(posedge clk_i);
  endtask
endmodule

// ---- tb_input_capture_channel.sv ----
`timescale 1ns/1ps
`include "input_capture_consts.svh"
module tb_input_capture_channel;
  logic clk, nrst, psel, penable, pwrite, pready, pslverr, irq, wake, idle, sleep, pin;
  logic clk_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] ta, tb_cnt;
  int fail_count = 0;
  int checks = 0;
  int wake_cnt = 0;
  // ==========================================================
  // clock, partner and design
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  capture_pin_model u_pin (.clk_i(clk), .pin_o(pin));
  input_capture_channel u_dut (.CLOCK_I(clk), .NRST_I(nrst), .CLK_EN_I(clk_en),
    .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .CAPTURE_INPUT_PIN_I(pin), .TIMER_A_COUNT_I(ta), .TIMER_B_COUNT_I(tb_cnt),
    .CPU_IDLE_I(idle), .CPU_SLEEP_I(sleep), .IRQ_O(irq), .WAKE_O(wake));
  // wake is a one-cycle pulse, so it is counted rather than polled
  always @(posedge clk) begin
    if (wake === 1'b1) wake_cnt++;
  end
  // ==========================================================
  // shared tasks
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // request held until pready is sampled high; bounded wait
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd_data, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      complete_run();
    end
    rd_data = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic e;
    apb(1'b1, a, d, x, e);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic e);
    apb(1'b0, a, 32'h0, d, e);
  endtask
  function automatic logic [31:0] cw(logic h, logic t, logic [1:0] i, logic [2:0] m);
    return {18'h0, h, 5'h0, t, i, 2'h0, m};
  endfunction
  // drain the buffer, counting entries; bounded so a stuck flag cannot hang
  task automatic drain(output int n);
    logic [31:0] d;
    logic e;
    n = 0;
    rd(`IC_OFF_CTRL, d, e);
    while (d[3] === 1'b1 && n < 6) begin
      rd(`IC_OFF_BUF, d, e);
      n++;
      rd(`IC_OFF_CTRL, d, e);
    end
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset_map();
    logic [31:0] d;
    logic e;
    rd(`IC_OFF_CTRL, d, e);
    check("ctrl reset", d, 32'h0);
    rd(`IC_OFF_MASK, d, e);
    check("mask reset", d, 32'h0);
    wr(12'h010, 32'hffff_ffff);
    rd(12'h010, d, e);
    check("unmapped data", d, 32'h0);
    check("unmapped err", {31'h0, e}, 32'h1);
  endtask
  task automatic t_timebase();
    logic [31:0] d;
    logic e;
    int n;
    ta <= 16'h1234;
    tb_cnt <= 16'habcd;
    wr(`IC_OFF_CTRL, cw(1'b0, 1'b1, 2'h0, 3'h3));
    u_pin.pulses(1);
    rd(`IC_OFF_CTRL, d, e);
    check("bne set", {31'h0, d[3]}, 32'h1);
    rd(`IC_OFF_BUF, d, e);
    check("timer a value", d, 32'h1234);
    wr(`IC_OFF_CTRL, cw(1'b0, 1'b0, 2'h0, 3'h3));
    u_pin.pulses(1);
    rd(`IC_OFF_BUF, d, e);
    check("timer b value", d, 32'habcd);
    drain(n);
    check("bne clear", 32'(n), 32'h0);
  endtask
  task automatic t_modes();
    int md[7] = '{2, 3, 1, 4, 5, 4, 6};
    int np[7] = '{2, 2, 1, 4, 16, 3, 2};
    int ex[7] = '{2, 2, 2, 1, 1, 0, 0};
    int n;
    for (int i = 0; i < 7; i++) begin
      wr(`IC_OFF_CTRL, 32'h0);
      wr(`IC_OFF_CTRL, cw(1'b0, 1'b1, 2'h0, md[i][2:0]));
      u_pin.pulses(np[i]);
      drain(n);
      check("captures per mode", 32'(n), 32'(ex[i]));
    end
  endtask
  task automatic t_fifo();
    logic [31:0] d;
    logic e;
    wr(`IC_OFF_CTRL, 32'h0);
    wr(`IC_OFF_CTRL, cw(1'b0, 1'b1, 2'h0, 3'h3));
    for (int i = 1; i <= 5; i++) begin
      ta <= 16'h0100 + 16'(i);
      u_pin.pulses(1);
      rd(`IC_OFF_CTRL, d, e);
      check("overflow flag", {31'h0, d[4]}, {31'h0, i == 5});
    end
    for (int i = 1; i <= 4; i++) begin
      rd(`IC_OFF_BUF, d, e);
      check("buffer order", d, 32'h0100 + 32'(i));
    end
    rd(`IC_OFF_CTRL, d, e);
    check("ovf kept bne clear", {30'h0, d[4:3]}, 32'h2);
    wr(`IC_OFF_CTRL, 32'h0);
    rd(`IC_OFF_CTRL, d, e);
    check("off clears flags", {30'h0, d[4:3]}, 32'h0);
  endtask
  task automatic t_irq();
    logic [31:0] d;
    logic e;
    for (int k = 0; k < 4; k++) begin
      wr(`IC_OFF_CTRL, 32'h0);
      wr(`IC_OFF_STAT, 32'h7);
      wr(`IC_OFF_MASK, 32'h1);
      wr(`IC_OFF_CTRL, cw(1'b0, 1'b1, 2'(k), 3'h3));
      u_pin.pulses(k);
      check("irq early", {31'h0, irq}, 32'h0);
      u_pin.pulses(1);
      check("irq on count", {31'h0, irq}, 32'h1);
    end
    wr(`IC_OFF_CTRL, 32'h0);
    wr(`IC_OFF_STAT, 32'h7);
    wr(`IC_OFF_CTRL, cw(1'b0, 1'b1, 2'h3, 3'h1));
    u_pin.pulses(1);
    check("both edges irq", {31'h0, irq}, 32'h1);
    wr(`IC_OFF_MASK, 32'h0);
    repeat (2) @(posedge clk);
    check("masked irq", {31'h0, irq}, 32'h0);
    wr(`IC_OFF_STAT, 32'h7);
    rd(`IC_OFF_STAT, d, e);
    check("status cleared", d, 32'h0);
  endtask
  task automatic t_idle_wake();
    logic [31:0] d;
    logic e;
    int n;
    int w0;
    wr(`IC_OFF_CTRL, 32'h0);
    idle <= 1'b1;
    wr(`IC_OFF_CTRL, cw(1'b1, 1'b1, 2'h0, 3'h3));
    u_pin.pulses(1);
    drain(n);
    check("halted in idle", 32'(n), 32'h0);
    wr(`IC_OFF_CTRL, cw(1'b0, 1'b1, 2'h0, 3'h3));
    w0 = wake_cnt;
    u_pin.pulses(1);
    drain(n);
    check("runs in idle", 32'(n), 32'h1);
    check("capture wakes", 32'(wake_cnt > w0), 32'h1);
    idle <= 1'b0;
    sleep <= 1'b1;
    wr(`IC_OFF_CTRL, 32'h0);
    wr(`IC_OFF_STAT, 32'h7);
    wr(`IC_OFF_CTRL, cw(1'b0, 1'b1, 2'h0, 3'h7));
    w0 = wake_cnt;
    u_pin.pulses(1);
    check("wake pulses", 32'(wake_cnt - w0), 32'h1);
    rd(`IC_OFF_STAT, d, e);
    check("wake status", {31'h0, d[2]}, 32'h1);
    drain(n);
    check("no capture in wake mode", 32'(n), 32'h0);
    sleep <= 1'b0;
  endtask
  // clock enable low freezes pin sampling; a mid-run reset empties everything
  task automatic t_freeze_reset();
    logic [31:0] d;
    logic e;
    int n;
    wr(`IC_OFF_CTRL, 32'h0);
    wr(`IC_OFF_CTRL, cw(1'b0, 1'b1, 2'h0, 3'h3));
    clk_en <= 1'b0;
    u_pin.pulses(1);
    clk_en <= 1'b1;
    drain(n);
    check("frozen pin ignored", 32'(n), 32'h0);
    u_pin.pulses(1);
    rd(`IC_OFF_CTRL, d, e);
    check("capture after enable", {31'h0, d[3]}, 32'h1);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd(`IC_OFF_CTRL, d, e);
    check("reset mid-run", d, 32'h0);
    check("irq after mid reset", {31'h0, irq}, 32'h0);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    nrst = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ta = 16'h0000;
    tb_cnt = 16'h0000;
    idle = 1'b0;
    sleep = 1'b0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    check("irq after reset", {31'h0, irq}, 32'h0);
    t_reset_map();
    t_timebase();
    t_modes();
    t_fifo();
    t_irq();
    t_idle_wake();
    t_freeze_reset();
    complete_run();
  end
endmodule
